// ==== shift_clock_consts.svh ====
// Offsets, field positions and reset values for the serial shift clock select block
`ifndef SHIFT_CLOCK_CONSTS_SVH
`define SHIFT_CLOCK_CONSTS_SVH
`define CTRL_OFFSET       12'h000
`define PINLOC_OFFSET     12'h004
`define DATA_OFFSET       12'h008
`define STATUS_OFFSET     12'h00c
`define CTRL_CS_HI        3
`define CTRL_CS_LO        2
`define CTRL_STROBE_BIT   1
`define CTRL_TOGGLE_BIT   0
`define CTRL_DIR_BIT      4
`define PINLOC_POS_BIT    0
`define CTRL_RESET        8'h00
`define PINLOC_RESET      8'h00
`endif

// ==== shift_clock_pkg.sv ====
// Types shared by the serial shift clock select block
package shift_clock_pkg;
   typedef enum logic [1:0] {
      cs_soft,
      cs_timer,
      cs_ext_pos,
      cs_ext_neg
   } clk_src_t;
endpackage

// ==== pin_sync.sv ====
// Two flip-flop synchroniser with a third stage for the edge outputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync
(
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Pin and result
   input  wire logic pin_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
   } sync_state_t;
   sync_state_t st_q;
   sync_state_t st_d;

   // Shift the pin through the stages
   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = pin_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign level = st_q.s2;
   assign rise  = st_q.s2 & ~st_q.s3;
   assign fall  = ~st_q.s2 & st_q.s3;
endmodule
`default_nettype wire

// ==== shift_counter.sv ====
// Data shift register with transfer counter
`timescale 1ns/100ps
`default_nettype none
module shift_counter
#(
   parameter int WIDTH  = 8,
   parameter int CWIDTH = 4
)
(
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // Shift and count strobes
   input  wire logic              shift_en,
   input  wire logic              count_en,
   input  wire logic              in_bit,
   // Software load
   input  wire logic              load,
   input  wire logic [WIDTH-1:0]  load_data,
   // State
   output logic      [WIDTH-1:0]  data,
   output logic      [CWIDTH-1:0] count
);
   typedef struct packed
   {
      logic [WIDTH-1:0]  data;
      logic [CWIDTH-1:0] count;
   } sc_state_t;
   sc_state_t st_q;
   sc_state_t st_d;

   // Shift left from the low end and count strobes
   always_comb
   begin
      st_d = st_q;
      if (load)
         st_d.data = load_data;
      else if (shift_en)
         st_d.data = {st_q.data[WIDTH-2:0], in_bit};
      if (count_en)
         st_d.count = st_q.count + CWIDTH'(1);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign data  = st_q.data;
   assign count = st_q.count;
endmodule
`default_nettype wire

// ==== shift_clock_select.sv ====
// Clock source selection, strobes and pin routing of the serial shift unit
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "shift_clock_consts.svh"
module shift_clock_select
(
   // AHB-Lite slave
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   hsel,
   input  wire logic [11:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // Timer compare match pulse
   input  wire logic                   timer_match,
   // Port B pins 2..0: data in, data out, clock
   input  wire logic                   pb_data_in,
   input  wire logic                   pb_clk_in,
   output logic                        pb_data_out,
   output logic                        pb_data_oe_n,
   output logic                        pb_clk_out,
   output logic                        pb_clk_oe_n,
   // Port A pins 2..0: data in, data out, clock
   input  wire logic                   pa_data_in,
   input  wire logic                   pa_clk_in,
   output logic                        pa_data_out,
   output logic                        pa_data_oe_n,
   output logic                        pa_clk_out,
   output logic                        pa_clk_oe_n,
   // Shift state seen by the rest of the unit
   output logic      [7:0]             shift_data,
   output logic      [3:0]             transfer_count
);
   import shift_clock_pkg::*;

   //----------------------------------------------------------------
   // State
   //----------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0]  ctrl;
      logic        pin_pos;
      logic        clk_port;
      logic        out_latch;
      logic        din_prev;
      logic        ph_write;
      logic        ph_read;
      logic [11:0] ph_addr;
      logic [31:0] rdata;
   } top_state_t;
   top_state_t st_q;
   top_state_t st_d;

   logic       din_lvl;
   logic       clk_rise;
   logic       clk_fall;
   logic       pb_din_s;
   logic       pa_din_s;
   logic       pb_ck_lvl;
   logic       pa_ck_lvl;
   logic       pb_ck_r;
   logic       pb_ck_f;
   logic       pa_ck_r;
   logic       pa_ck_f;
   logic       wr_ctrl;
   logic       strobe_pulse;
   logic       toggle_pulse;
   logic       shift_en;
   logic       count_en;
   logic       load;
   logic       dir_out;
   logic       data_out;
   logic [7:0] sdata;
   logic [3:0] scount;
   clk_src_t   src;

   //----------------------------------------------------------------
   // Pin synchronisers
   //----------------------------------------------------------------
   pin_sync u_pb_din
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  (pb_data_in),
      .level   (pb_din_s),
      .rise    (),
      .fall    ()
   );
   pin_sync u_pa_din
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  (pa_data_in),
      .level   (pa_din_s),
      .rise    (),
      .fall    ()
   );
   pin_sync u_pb_ck
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  (pb_clk_in),
      .level   (pb_ck_lvl),
      .rise    (pb_ck_r),
      .fall    (pb_ck_f)
   );
   pin_sync u_pa_ck
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  (pa_clk_in),
      .level   (pa_ck_lvl),
      .rise    (pa_ck_r),
      .fall    (pa_ck_f)
   );

   // Pick the active pin set
   assign din_lvl  = st_q.pin_pos ? pa_din_s : pb_din_s;
   assign clk_rise = st_q.pin_pos ? pa_ck_r : pb_ck_r;
   assign clk_fall = st_q.pin_pos ? pa_ck_f : pb_ck_f;

   //----------------------------------------------------------------
   // Strobes and clock source decode
   //----------------------------------------------------------------
   assign src     = clk_src_t'(st_q.ctrl[`CTRL_CS_HI:`CTRL_CS_LO]);
   assign dir_out = st_q.ctrl[`CTRL_DIR_BIT];
   assign wr_ctrl = st_q.ph_write && (st_q.ph_addr == `CTRL_OFFSET);
   assign load    = st_q.ph_write && (st_q.ph_addr == `DATA_OFFSET);

   // Write-one strobes, live only in the data phase cycle
   assign strobe_pulse = wr_ctrl && hwdata[`CTRL_STROBE_BIT];
   assign toggle_pulse = wr_ctrl && hwdata[`CTRL_TOGGLE_BIT];

   // Shift and count enables per clock source
   always_comb
   begin
      shift_en = 1'b0;
      count_en = 1'b0;
      case (src)
         cs_soft:
         begin
            shift_en = strobe_pulse;
            count_en = strobe_pulse;
         end
         cs_timer:
         begin
            shift_en = timer_match;
            count_en = timer_match;
         end
         cs_ext_pos:
         begin
            shift_en = clk_rise;
            count_en = st_q.ctrl[`CTRL_STROBE_BIT] ? toggle_pulse
                                                   : (clk_rise | clk_fall);
         end
         cs_ext_neg:
         begin
            shift_en = clk_fall;
            count_en = st_q.ctrl[`CTRL_STROBE_BIT] ? toggle_pulse
                                                   : (clk_rise | clk_fall);
         end
         default:
         begin
            shift_en = 1'b0;
            count_en = 1'b0;
         end
      endcase
   end

   //----------------------------------------------------------------
   // Shift register and counter
   //----------------------------------------------------------------
   shift_counter #(.WIDTH(8), .CWIDTH(4)) u_shift
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .shift_en  (shift_en),
      .count_en  (count_en),
      .in_bit    (src == cs_soft ? st_q.din_prev : din_lvl),
      .load      (load),
      .load_data (hwdata[7:0]),
      .data      (sdata),
      .count     (scount)
   );

   // Output: transparent for internal clocks, latched on opposite edge externally
   assign data_out = src[1] ? st_q.out_latch : sdata[7];

   //----------------------------------------------------------------
   // Next state
   //----------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      // Address phase capture
      st_d.ph_write = hsel && hready && htrans[1] && hwrite;
      st_d.ph_read  = hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1])
         st_d.ph_addr = haddr;
      // Data input sampled each cycle for the strobe path
      st_d.din_prev = din_lvl;
      // Control: toggle bit never stored, strobe bit stored only when an external source is written
      if (wr_ctrl)
      begin
         st_d.ctrl = hwdata[7:0];
         st_d.ctrl[`CTRL_STROBE_BIT] = (hwdata[`CTRL_CS_HI] == 1'b1) ? hwdata[`CTRL_STROBE_BIT] : 1'b0;
         st_d.ctrl[`CTRL_TOGGLE_BIT] = 1'b0;
      end
      if (st_q.ph_write && (st_q.ph_addr == `PINLOC_OFFSET))
         st_d.pin_pos = hwdata[`PINLOC_POS_BIT];
      // Toggle inverts the clock port value regardless of direction
      if (toggle_pulse)
         st_d.clk_port = ~st_q.clk_port;
      // Latch follows the register under internal clocks, so the first external bit is ready
      if (!src[1])
         st_d.out_latch = sdata[7];
      // Output latch loads on edge opposite to the sampling edge
      if ((src == cs_ext_pos && clk_fall) || (src == cs_ext_neg && clk_rise))
         st_d.out_latch = sdata[7];
      // Read data for the next data phase
      st_d.rdata = 32'h0000_0000;
      if (st_d.ph_read)
      begin
         case (haddr)
            `CTRL_OFFSET:
               st_d.rdata = {24'h00_0000, st_q.ctrl[7:2], 2'b00};
            `PINLOC_OFFSET:
               st_d.rdata = {31'h0000_0000, st_q.pin_pos};
            `DATA_OFFSET:
               st_d.rdata = {24'h00_0000, sdata};
            `STATUS_OFFSET:
               st_d.rdata = {27'h000_0000, (st_q.pin_pos ? pa_ck_lvl : pb_ck_lvl), scount};
            default:
               st_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q         <= '0;
         st_q.ctrl    <= `CTRL_RESET;
         st_q.pin_pos <= 1'(`PINLOC_RESET);
      end
      else
         st_q <= st_d;
   end

   //----------------------------------------------------------------
   // Bus answer and pins
   //----------------------------------------------------------------
   assign hrdata    = st_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Route to port B when location is zero, port A when one
   assign pb_data_out  = st_q.pin_pos ? 1'b0 : data_out;
   assign pb_data_oe_n = st_q.pin_pos ? 1'b1 : 1'b0;
   assign pb_clk_out   = st_q.pin_pos ? 1'b0 : st_q.clk_port;
   assign pb_clk_oe_n  = st_q.pin_pos ? 1'b1 : ~dir_out;
   assign pa_data_out  = st_q.pin_pos ? data_out : 1'b0;
   assign pa_data_oe_n = st_q.pin_pos ? 1'b0 : 1'b1;
   assign pa_clk_out   = st_q.pin_pos ? st_q.clk_port : 1'b0;
   assign pa_clk_oe_n  = st_q.pin_pos ? ~dir_out : 1'b1;

   assign shift_data     = sdata;
   assign transfer_count = scount;
endmodule
`default_nettype wire

// ==== shift_clock_select_assertions.sv ====
// Concurrent checks on the ports of the shift clock select block
`timescale 1ns/100ps
`default_nettype none
`include "shift_clock_consts.svh"
module shift_clock_select_checker
(
   // Bus side
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Unit side
   input wire logic        timer_match,
   input wire logic        pb_data_out,
   input wire logic        pb_data_oe_n,
   input wire logic        pa_data_oe_n,
   input wire logic        pb_clk_out,
   input wire logic [7:0]  shift_data,
   input wire logic [3:0]  transfer_count
);
   // ----------------------------------------
   // Data phase and control shadow
   // ----------------------------------------
   logic        wr_q, rd_q, sel_q;
   logic [11:0] a_q;
   logic [1:0]  src_q;
   wire         ctrl_wr = wr_q && a_q == `CTRL_OFFSET;
   // Tracks what software last wrote to control
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {wr_q, rd_q, sel_q, src_q, a_q} <= '0;
      end
      else
      begin
         wr_q <= hsel && hready && htrans[1] && hwrite;
         rd_q <= hsel && hready && htrans[1] && !hwrite;
         a_q  <= haddr;
         if (ctrl_wr)
         begin
            src_q <= hwdata[3:2];
            if (hwdata[3])
               sel_q <= hwdata[1];
         end
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence strobe_s;
      ctrl_wr && hwdata[1] && hwdata[3:2] == 2'b00 && src_q == 2'b00;
   endsequence
   sequence toggle_cnt_s;
      ctrl_wr && hwdata[0] && hwdata[3] && hwdata[1] && src_q[1] && sel_q;
   endsequence
   bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not OKAY");
   strobe_count_a: assert property (strobe_s |=> transfer_count == $past(transfer_count) + 4'h1)
      else $error("strobe did not count once");
   idle_count_a: assert property (src_q == 2'b00 && !ctrl_wr |=> $stable(transfer_count))
      else $error("counter moved with no clock");
   timer_count_a: assert property (src_q == 2'b01 && timer_match && !ctrl_wr
      |=> transfer_count == $past(transfer_count) + 4'h1) else $error("timer match not counted");
   count_step_a: assert property ($changed(transfer_count)
      |-> transfer_count == $past(transfer_count) + 4'h1) else $error("counter jumped");
   transparent_out_a: assert property (!src_q[1] && !pb_data_oe_n |-> pb_data_out == shift_data[7])
      else $error("output latch not transparent");
   held_count_a: assert property (src_q[1] && sel_q && !ctrl_wr |=> $stable(transfer_count))
      else $error("counter moved without toggle");
   toggle_count_a: assert property (toggle_cnt_s |=> transfer_count == $past(transfer_count) + 4'h1)
      else $error("toggle did not count");
   toggle_pin_a: assert property (ctrl_wr && hwdata[0] && !pb_data_oe_n |=> pb_clk_out != $past(pb_clk_out))
      else $error("clock port value not inverted");
   ctrl_read_a: assert property (rd_q && a_q == `CTRL_OFFSET |-> hrdata[1:0] == 2'b00)
      else $error("strobe bits read nonzero");
   pinloc_read_a: assert property (rd_q && a_q == `PINLOC_OFFSET |-> hrdata[7:1] == 7'h00)
      else $error("reserved location bits nonzero");
   one_port_a: assert property (pb_data_oe_n != pa_data_oe_n) else $error("port routing wrong");
endmodule
bind shift_clock_select shift_clock_select_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer_match, .pb_data_out, .pb_data_oe_n, .pa_data_oe_n,
   .pb_clk_out, .shift_data, .transfer_count);
`default_nettype wire

// ==== serial_far_master.sv ====
// Behavioural serial master on the far side of the shift unit
`timescale 1ns/100ps
`default_nettype none
module serial_far_master
(
   // Frame control
   input  wire logic       go,
   input  wire logic       neg,
   input  wire logic [7:0] tx,
   output logic            busy,
   output logic [7:0]      rx,
   // Serial lines
   output logic            sclk,
   output logic            sdo,
   input  wire logic       sdi
);
   // Clock idles low between frames
   initial
   begin
      {busy, sclk, sdo, rx} = '0;
   end
   // Eight 800 ns periods, MSB first, data moved on the non-sampling edge
   always @(posedge go)
   begin
      busy = 1'b1;
      #37 sdo = tx[7];
      for (int i = 7; i >= 0; i--)
      begin
         #400 sclk = 1'b1;
         rx = {rx[6:0], sdi};
         if (neg)
            sdo = tx[i];
         #400 sclk = 1'b0;
         if (!neg && i > 0)
            sdo = tx[i-1];
      end
      // Released line shows the inverse of its last bit
      #400 sdo = ~sdo;
      busy = 1'b0;
   end
endmodule
`default_nettype wire

// ==== serial_shift_clock_select_tb_top.sv ====
// Self-checking bench for the shift clock select block
`timescale 1ns/100ps
`default_nettype none
`include "shift_clock_consts.svh"
module serial_shift_clock_select_tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        hclk, hresetn, hsel, hwrite, hreadyout, timer_match, din_q, use_far, go, neg, busy, sclk, sdo;
   logic        pb_data_out, pb_data_oe_n, pb_clk_out, pb_clk_oe_n, pa_data_oe_n, rd_ph;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata;
   logic [31:0] exp_q[$];
   logic [7:0]  tx, rx, sh, pre, shift_data;
   logic [3:0]  cnt, transfer_count;
   int          errors, total_checks;
   shift_clock_select dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .timer_match, .pb_data_in(use_far ? sdo : din_q),
      .pb_clk_in(sclk), .pb_data_out, .pb_data_oe_n, .pb_clk_out, .pb_clk_oe_n, .pa_data_in(1'b0),
      .pa_clk_in(1'b0), .pa_data_out(), .pa_data_oe_n, .pa_clk_out(), .pa_clk_oe_n(), .shift_data,
      .transfer_count);
   serial_far_master far (.go, .neg, .tx, .busy, .rx, .sclk, .sdo, .sdi(pb_data_out));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] e);
      total_checks++;
      if (got !== e)
      begin
         errors++;
         $display("CHECK FAILED at %0t: got 0x%h expected 0x%h", $time, got, e);
      end
   endtask
   task automatic wrap_up;
      if (errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One single transfer, address phase then data phase
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic pin(input logic [31:0] got, input logic [31:0] e);
      check(got, e);
   endtask
   // External master sends one random byte
   task automatic frame(input logic n);
      tx      <= 8'($urandom);
      neg     <= n;
      use_far <= 1'b1;
      go      <= 1'b1;
      repeat (2) @(posedge hclk);
      go <= 1'b0;
      do @(posedge hclk); while (busy);
      repeat (6) @(posedge hclk);
      pre = sh;
      sh  = tx;
   endtask
   // ----------------------------------------
   // Clock, monitor, watchdog
   // ----------------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // Read data is taken at the edge that ends the data phase
   always @(posedge hclk)
   begin
      if (rd_ph)
         check(hrdata, exp_q.pop_front());
      rd_ph = hsel && htrans[1] && !hwrite && hreadyout;
   end
   initial
   begin
      #200_000;
      errors++;
      wrap_up();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'h9b18));
      {hresetn, hsel, hwrite, timer_match, din_q, use_far, go, neg, rd_ph, haddr, htrans, hwdata, tx} = '0;
      {errors, total_checks, cnt} = '0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`CTRL_OFFSET, 32'h0000_0000);
      rd(`PINLOC_OFFSET, 32'h0000_0000);
      sh = 8'($urandom);
      xfer(1'b1, `DATA_OFFSET, {24'h00_0000, sh});
      for (int i = 0; i < 4; i++)
      begin
         din_q <= 1'($urandom);
         repeat (4) @(posedge hclk);
         sh = {sh[6:0], din_q};
         cnt++;
         xfer(1'b1, `CTRL_OFFSET, 32'h0000_00b2);
      end
      @(negedge hclk);
      pin({31'h0000_0000, pb_data_out}, {31'h0000_0000, sh[7]});
      pin({30'h0000_0000, pb_data_oe_n, pa_data_oe_n}, 32'h0000_0001);
      @(posedge hclk);
      rd(`CTRL_OFFSET, 32'h0000_00b0);
      xfer(1'b1, `CTRL_OFFSET, 32'h0000_0011);
      @(negedge hclk);
      pin({30'h0000_0000, pb_clk_oe_n, pb_clk_out}, 32'h0000_0001);
      @(posedge hclk);
      xfer(1'b1, `CTRL_OFFSET, 32'h0000_0001);
      @(negedge hclk);
      pin({30'h0000_0000, pb_clk_oe_n, pb_clk_out}, 32'h0000_0002);
      @(posedge hclk);
      xfer(1'b1, `CTRL_OFFSET, 32'h0000_0004);
      xfer(1'b1, `CTRL_OFFSET, 32'h0000_0006);
      for (int i = 0; i < 3; i++)
      begin
         timer_match <= 1'b1;
         @(posedge hclk);
         timer_match <= 1'b0;
         repeat (2) @(posedge hclk);
         sh = {sh[6:0], din_q};
         cnt++;
      end
      rd(`DATA_OFFSET, {24'h00_0000, sh});
      rd(`STATUS_OFFSET, {28'h000_0000, cnt});
      xfer(1'b1, `CTRL_OFFSET, 32'h0000_0008);
      frame(1'b0);
      pin({24'h00_0000, rx}, {24'h00_0000, pre});
      rd(`DATA_OFFSET, {24'h00_0000, sh});
      xfer(1'b1, `CTRL_OFFSET, 32'h0000_000c);
      frame(1'b1);
      rd(`DATA_OFFSET, {24'h00_0000, sh});
      rd(`STATUS_OFFSET, {28'h000_0000, cnt});
      xfer(1'b1, `CTRL_OFFSET, 32'h0000_000a);
      frame(1'b0);
      rd(`STATUS_OFFSET, {28'h000_0000, cnt});
      for (int i = 0; i < 3; i++)
      begin
         cnt++;
         xfer(1'b1, `CTRL_OFFSET, 32'h0000_001b);
      end
      rd(`STATUS_OFFSET, {28'h000_0000, cnt});
      rd(`CTRL_OFFSET, 32'h0000_0018);
      pin({31'h0000_0000, pb_clk_out}, 32'h0000_0001);
      xfer(1'b1, `PINLOC_OFFSET, 32'hffff_ffff);
      rd(`PINLOC_OFFSET, 32'h0000_0001);
      xfer(1'b1, 12'h010, 32'hffff_ffff);
      rd(12'h010, 32'h0000_0000);
      @(negedge hclk);
      pin({30'h0000_0000, pb_data_oe_n, pa_data_oe_n}, 32'h0000_0002);
      wrap_up();
   end
endmodule
`default_nettype wire
